// [bench/host_bus_model.sv]
// host processor model for the parallel bus port
// assumes one clock; all bus signals change just after rising edges
// serial receive lines are not on this port; their sender idles them high
`timescale 1ns/1ps
module host_bus_model (
  // clock
  input  wire logic       sys_clk_in,
  // device side of the data bus
  input  wire logic [7:0] bus_data_out_in,
  input  wire logic       bus_data_oe_n_in,
  // bus pins to the device
  output logic      [2:0] reg_addr_out,
  output logic      [7:0] bus_wire_out,
  output logic            read_strobe_n_out,
  output logic            write_strobe_n_out,
  output logic            chan_a_select_n_out,
  output logic            chan_b_select_n_out
);
  logic [7:0] wdata;
  logic       drive;
  logic [7:0] junk;
  initial begin
    reg_addr_out = 3'h0;
    wdata = 8'h00;
    drive = 1'b0;
    junk = 8'hA5;
    read_strobe_n_out = 1'b1;
    write_strobe_n_out = 1'b1;
    chan_a_select_n_out = 1'b1;
    chan_b_select_n_out = 1'b1;
  end
  // released bus keeps moving so stale bytes never pass for data
  always @(posedge sys_clk_in) junk <= ~junk;
  assign bus_wire_out = !bus_data_oe_n_in ? bus_data_out_in : (drive ? wdata : junk);
  ////////////////////////////////////////////////////////////////////////////////
  // one access; gp output never used by the host
  task automatic access(input logic rd, input logic [1:0] sel_n, input logic [2:0] addr,
                        input logic [7:0] wd, output logic [7:0] rdata, output logic oe_n);
    @(posedge sys_clk_in);
    chan_a_select_n_out <= sel_n[0];
    chan_b_select_n_out <= sel_n[1];
    reg_addr_out <= addr;
    wdata <= wd;
    drive <= !rd;
    @(posedge sys_clk_in);
    if (rd) read_strobe_n_out <= 1'b0;
    else write_strobe_n_out <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rdata = bus_wire_out;
    oe_n = bus_data_oe_n_in;
    read_strobe_n_out <= 1'b1;
    write_strobe_n_out <= 1'b1;
    // data and select held past the synchronisers before release
    repeat (4) @(posedge sys_clk_in);
    drive <= 1'b0;
    chan_a_select_n_out <= 1'b1;
    chan_b_select_n_out <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
  endtask
endmodule

// [bench/test_dual_uart_host_bus_port.sv]
// self-checking bench for the host bus port
// assumes the host model drives every bus pin; irq sources come from here
`timescale 1ns/1ps
module test_dual_uart_host_bus_port;
  import dual_uart_port_pkg::*;
  logic       sys_clk_in, rst_in, src_a, src_b, rd_n, wr_n, sa_n, sb_n, oe_n;
  logic       irq_a, oe_a, gp_a, irq_b, oe_b, gp_b, got_oe;
  logic [2:0] addr;
  logic [7:0] wire_d, dout, got;
  int         n_mismatch, compares, cycles;
  dual_uart_host_bus_port DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .bus_data_in(wire_d), .bus_data_out(dout), .bus_data_oe_n_out(oe_n),
    .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .chan_a_select_n_in(sa_n),
    .chan_b_select_n_in(sb_n), .irq_src_chan_a_in(src_a), .irq_src_chan_b_in(src_b),
    .irq_out_chan_a_out(irq_a), .irq_out_chan_a_oe_n_out(oe_a), .gp_out2_chan_a_n_out(gp_a),
    .irq_out_chan_b_out(irq_b), .irq_out_chan_b_oe_n_out(oe_b), .gp_out2_chan_b_n_out(gp_b));
  host_bus_model host (.sys_clk_in(sys_clk_in), .bus_data_out_in(dout),
    .bus_data_oe_n_in(oe_n), .reg_addr_out(addr), .bus_wire_out(wire_d),
    .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n), .chan_a_select_n_out(sa_n),
    .chan_b_select_n_out(sb_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // byte pattern with bit 3 clear at the modem control index
  function automatic logic [7:0] pat(input logic ch, input logic [2:0] a);
    return {1'b1, ch, a, 3'h1};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check({4'h0, oe_n, oe_a, gp_a, gp_b}, 8'h0F, "idle pins after reset");
    check({7'h0, oe_b}, 8'h01, "irq b floats after reset");
    host.access(1'b1, 2'b01, 3'h0, 8'h00, got, got_oe);
    check(got, REG_RESET, "reset register value");
    $display("test_reset done");
  endtask
  task automatic test_regs();
    for (int c = 0; c < 2; c++)
      for (int a = 0; a < 8; a++)
        host.access(1'b0, c ? 2'b01 : 2'b10, a[2:0], pat(c[0], a[2:0]), got, got_oe);
    for (int c = 0; c < 2; c++)
      for (int a = 0; a < 8; a++) begin
        host.access(1'b1, c ? 2'b01 : 2'b10, a[2:0], 8'h00, got, got_oe);
        check(got, pat(c[0], a[2:0]), "register read back");
        check({7'h0, got_oe}, 8'h00, "bus driven on read");
      end
    $display("test_regs done");
  endtask
  task automatic test_irq(input logic ch);
    host.access(1'b0, ch ? 2'b01 : 2'b10, MCR_INDEX, 8'h08, got, got_oe);
    if (ch) src_b <= 1'b1;
    else src_a <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    got = ch ? {3'h0, irq_b, oe_b, gp_b, oe_a, gp_a} : {3'h0, irq_a, oe_a, gp_a, oe_b, gp_b};
    check(got, 8'h13, "irq driven and gp low, other channel idle");
    host.access(1'b0, ch ? 2'b01 : 2'b10, MCR_INDEX, 8'h00, got, got_oe);
    got = ch ? {6'h0, oe_b, gp_b} : {6'h0, oe_a, gp_a};
    check(got, 8'h03, "irq floats and gp high");
    src_a <= 1'b0;
    src_b <= 1'b0;
    $display("test_irq done");
  endtask
  task automatic test_refused();
    host.access(1'b0, 2'b00, 3'h2, 8'h55, got, got_oe);
    host.access(1'b0, 2'b11, 3'h2, 8'h66, got, got_oe);
    host.access(1'b1, 2'b11, 3'h2, 8'h00, got, got_oe);
    check({7'h0, got_oe}, 8'h01, "bus floats without select");
    host.access(1'b1, 2'b00, 3'h2, 8'h00, got, got_oe);
    check({7'h0, got_oe}, 8'h01, "bus floats with both selects");
    host.access(1'b1, 2'b10, 3'h2, 8'h00, got, got_oe);
    check(got, pat(1'b0, 3'h2), "refused writes left register");
    $display("test_refused done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_in = 1'b0;
    forever #(CLK_PERIOD_NS / 2) sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    rst_in = 1'b1;
    src_a = 1'b0;
    src_b = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    test_reset();
    test_regs();
    test_irq(1'b0);
    test_irq(1'b1);
    test_refused();
    give_verdict();
  end
endmodule

// [src/dual_uart_host_bus_port.sv]
// host-side parallel bus port of a two-channel serial controller
// assumes host strobes, selects, address and data are asynchronous to sys_clk_in
// and that the host holds address and data stable around each strobe
//
// Notes on behaviour
// - three address bits pick a channel register
// - eight-bit data bus, driven on reads
// - read strobe fall starts read, drives byte
// - write byte loaded at write strobe rise
// - only the selected channel answers the bus
// - two independent channels, each own registers
// - enable bit set: drive irq, gp low
// - enable bit clear: float irq, gp high
`timescale 1ns/1ps
module dual_uart_host_bus_port (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // host bus
  input  wire logic [2:0] reg_addr_in,
  input  wire logic [7:0] bus_data_in,
  output logic      [7:0] bus_data_out,
  output logic            bus_data_oe_n_out,
  input  wire logic       read_strobe_n_in,
  input  wire logic       write_strobe_n_in,
  input  wire logic       chan_a_select_n_in,
  input  wire logic       chan_b_select_n_in,
  // interrupt sources from the channel cores
  input  wire logic       irq_src_chan_a_in,
  input  wire logic       irq_src_chan_b_in,
  // interrupt pins and general-purpose outputs
  output logic            irq_out_chan_a_out,
  output logic            irq_out_chan_a_oe_n_out,
  output logic            gp_out2_chan_a_n_out,
  output logic            irq_out_chan_b_out,
  output logic            irq_out_chan_b_oe_n_out,
  output logic            gp_out2_chan_b_n_out
);
  import dual_uart_port_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] flt;
    phase_t            phase;
    logic              cap_a;
    logic [2:0]        cap_addr;
    logic [7:0]        cap_data;
    logic              wr_a;
    logic              wr_b;
    logic [7:0]        dout;
    logic              oe_n;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;

  logic [2:0] rd_addr;
  logic [7:0] rd_data_a;
  logic [7:0] rd_data_b;
  logic       sel_a;
  logic       sel_b;
  logic       one_sel;
  // filtered pin levels as they stand after this edge
  logic [SYNC_W-1:0] flt_next;

  // a level moves only when the second and third stage agree
  function automatic logic [SYNC_W-1:0] settle(input logic [SYNC_W-1:0] old,
                                               input logic [SYNC_W-1:0] b,
                                               input logic [SYNC_W-1:0] c);
    settle = (old & (b ^ c)) | (c & ~(b ^ c));
  endfunction

  function automatic logic fell(input logic old, input logic now);
    fell = old & ~now;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // channel register sets
  // kept apart from next_st so the read mux does not loop back into the sequencer
  assign flt_next = settle(st.flt, st.s2, st.s3);
  assign rd_addr  = (st.phase == PH_IDLE) ? flt_next[ADDR_LSB +: 3] : st.cap_addr;

  uart_chan_regs chan_a_regs (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .wr_in         (st.wr_a),
    .wr_addr_in    (st.cap_addr),
    .wr_data_in    (st.cap_data),
    .rd_addr_in    (rd_addr),
    .rd_data_out   (rd_data_a),
    .irq_src_in    (irq_src_chan_a_in),
    .irq_out       (irq_out_chan_a_out),
    .irq_oe_n_out  (irq_out_chan_a_oe_n_out),
    .gp_out2_n_out (gp_out2_chan_a_n_out)
  );

  uart_chan_regs chan_b_regs (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .wr_in         (st.wr_b),
    .wr_addr_in    (st.cap_addr),
    .wr_data_in    (st.cap_data),
    .rd_addr_in    (rd_addr),
    .rd_data_out   (rd_data_b),
    .irq_src_in    (irq_src_chan_b_in),
    .irq_out       (irq_out_chan_b_out),
    .irq_oe_n_out  (irq_out_chan_b_oe_n_out),
    .gp_out2_n_out (gp_out2_chan_b_n_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // access sequencing
  always_comb begin
    next_st      = st;
    next_st.s1   = {bus_data_in, reg_addr_in, chan_b_select_n_in, chan_a_select_n_in,
                    write_strobe_n_in, read_strobe_n_in};
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.flt  = flt_next;
    next_st.wr_a = 1'b0;
    next_st.wr_b = 1'b0;
    // both selects low is treated as no select, so no bus fight between channels
    sel_a   = ~next_st.flt[SEL_A_POS];
    sel_b   = ~next_st.flt[SEL_B_POS];
    one_sel = sel_a ^ sel_b;
    case (st.phase)
      PH_IDLE: begin
        if (fell(st.flt[RD_POS], next_st.flt[RD_POS]) && one_sel) begin
          next_st.phase    = PH_READ;
          next_st.cap_a    = sel_a;
          next_st.cap_addr = next_st.flt[ADDR_LSB +: 3];
          next_st.dout     = sel_a ? rd_data_a : rd_data_b;
          next_st.oe_n     = 1'b0;
        end else if (fell(st.flt[WR_POS], next_st.flt[WR_POS]) && one_sel) begin
          next_st.phase    = PH_WRITE;
          next_st.cap_a    = sel_a;
          next_st.cap_addr = next_st.flt[ADDR_LSB +: 3];
          next_st.cap_data = next_st.flt[DATA_LSB +: 8];
        end
      end
      PH_READ: begin
        // byte stands until the strobe rises so the host can take it then
        if (next_st.flt[RD_POS]) begin
          next_st.phase = PH_IDLE;
          next_st.oe_n  = 1'b1;
        end
      end
      PH_WRITE: begin
        if (next_st.flt[WR_POS]) begin
          next_st.phase = PH_IDLE;
          next_st.wr_a  = st.cap_a;
          next_st.wr_b  = ~st.cap_a;
        end else begin
          next_st.cap_data = next_st.flt[DATA_LSB +: 8];
        end
      end
      default: begin
        next_st.phase = PH_IDLE;
        next_st.oe_n  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '{s1: SYNC_RESET, s2: SYNC_RESET, s3: SYNC_RESET, flt: SYNC_RESET,
              phase: PH_IDLE, cap_a: 1'b0, cap_addr: 3'h0, cap_data: DATA_IDLE,
              wr_a: 1'b0, wr_b: 1'b0, dout: DATA_IDLE, oe_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign bus_data_out      = st.dout;
  assign bus_data_oe_n_out = st.oe_n;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  AST_READ_BYTE: assert property (
    (st.phase == PH_READ) |-> (bus_data_out == (st.cap_a ? rd_data_a : rd_data_b)))
    else $error("read byte differs from addressed register");

  AST_READ_START: assert property (
    (st.phase == PH_IDLE && fell(st.flt[RD_POS], next_st.flt[RD_POS]) && one_sel)
    |=> (!bus_data_oe_n_out && st.phase == PH_READ))
    else $error("read strobe fall did not drive the bus");

  AST_READ_HOLD: assert property (
    (st.phase == PH_READ && !next_st.flt[RD_POS]) |=> $stable(bus_data_out) && !bus_data_oe_n_out)
    else $error("read byte changed while strobe low");

  AST_BUS_FLOAT: assert property (
    (st.phase != PH_READ) |-> bus_data_oe_n_out)
    else $error("data bus driven outside a read");

  AST_WRITE_LOAD: assert property (
    (st.phase == PH_WRITE && next_st.flt[WR_POS]) |=> ((st.wr_a || st.wr_b) ##1 !(st.wr_a || st.wr_b)))
    else $error("write strobe rise did not load exactly once");

  AST_ONE_CHANNEL: assert property (
    !(st.wr_a && st.wr_b))
    else $error("write reached both channels");

  AST_CHAN_ROUTE: assert property (
    st.wr_a |-> ($past(st.cap_a) && $past(st.phase) == PH_WRITE))
    else $error("write to channel a without its select");

  AST_NO_SEL_IGNORED: assert property (
    (st.phase == PH_IDLE && !one_sel) |=> (st.phase == PH_IDLE))
    else $error("access taken without a single select");

  CV_READ_A:  cover property ((st.phase == PH_READ && st.cap_a) ##[1:50] st.phase == PH_IDLE);
  CV_WRITE_B: cover property (st.wr_b);
  CV_WRITE_A_MCR: cover property (st.wr_a && st.cap_addr == MCR_INDEX);

endmodule

// [src/dual_uart_port_pkg.sv]
// constants and types shared by the host bus port and its channel register sets
// assumes one 100 MHz clock; all host pins are asynchronous to it
package dual_uart_port_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 10;

  // synchroniser vector layout: strobes, selects, address, data
  localparam int SYNC_W    = 15;
  localparam int RD_POS    = 0;
  localparam int WR_POS    = 1;
  localparam int SEL_A_POS = 2;
  localparam int SEL_B_POS = 3;
  localparam int ADDR_LSB  = 4;
  localparam int DATA_LSB  = 7;

  // strobes and selects idle high after reset
  localparam logic [14:0] SYNC_RESET = 15'h000F;

  // per-channel register set
  localparam int          REG_COUNT      = 8;
  localparam logic [2:0]  MCR_INDEX      = 3'h4;
  localparam int          MCR_IRQ_EN_BIT = 3;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  DATA_IDLE      = 8'h00;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_READ  = 2'b01,
    PH_WRITE = 2'b10
  } phase_t;

endpackage

// [src/uart_chan_regs.sv]
// register set of one serial channel plus its interrupt pin control
// assumes write pulses and addresses come from the host bus port on the same clock
`timescale 1ns/1ps
module uart_chan_regs (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // register access from the bus port
  input  wire logic       wr_in,
  input  wire logic [2:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [2:0] rd_addr_in,
  output logic      [7:0] rd_data_out,
  // interrupt from the channel core, same clock
  input  wire logic       irq_src_in,
  // interrupt pin and general-purpose output
  output logic            irq_out,
  output logic            irq_oe_n_out,
  output logic            gp_out2_n_out
);
  import dual_uart_port_pkg::*;

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
    logic                      irq;
    logic                      oe_n;
    logic                      gp_n;
  } chan_state_t;

  chan_state_t st;
  chan_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (wr_in) begin
      next_st.regs[wr_addr_in] = wr_data_in;
    end
    next_st.irq  = irq_src_in;
    next_st.oe_n = ~st.regs[MCR_INDEX][MCR_IRQ_EN_BIT];
    next_st.gp_n = ~st.regs[MCR_INDEX][MCR_IRQ_EN_BIT];
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '{regs: {REG_COUNT{REG_RESET}}, irq: 1'b0, oe_n: 1'b1, gp_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // read mux is plain; the bus port registers the byte before the pins
  assign rd_data_out   = st.regs[rd_addr_in];
  assign irq_out       = st.irq;
  assign irq_oe_n_out  = st.oe_n;
  assign gp_out2_n_out = st.gp_n;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  AST_IRQ_DRIVEN: assert property (
    st.regs[MCR_INDEX][MCR_IRQ_EN_BIT] |=> (!irq_oe_n_out && !gp_out2_n_out))
    else $error("interrupt pin not driven with enable bit set");

  AST_IRQ_FLOAT: assert property (
    !st.regs[MCR_INDEX][MCR_IRQ_EN_BIT] |=> (irq_oe_n_out && gp_out2_n_out))
    else $error("interrupt pin driven with enable bit clear");

  CV_IRQ_ENABLE: cover property ($fell(irq_oe_n_out));

endmodule
